// [tx_interpolation_gain_control.sv]
// Transmit interpolator, attenuation control and serial register file.
// Notes on behaviour
// - Attenuation splits: converter 7.5 dB, amplifier 12 dB, 19.5 dB in all.
// - One 6-bit gain word, mapped to stage settings.
// - Direct output: only four low bits count.
// - Attenuation loads from parallel port or serial.
// - Serial writes and reads attenuation code.
// - Reset: zero attenuation, parallel port not routed.
// - Port select bits route port to gains.
// - Format bits choose 4x or 2x.
// - Input rate and converter rate limits respected.
// - Two cascaded half-band stages, 43 and 11.
// - Latency 21.5 or 24 input periods.
// - Bypass sends input words straight out.
// - Half-duplex power-down waits programmable delay.
// - Routing bit zero disables the amplifier.
// - Mirror gain 0 to 4, resets to 4.
// - Mirror writes ignored without override bit.
// - Parallel port loads with no strobe.
module tx_interpolation_gain_control
	import tx_gain_pkg::*;
#(
	parameter int DLY_DEPTH = 64,
	parameter int PD_DLY_W  = 8
) (
	input  wire logic                     i_mclk,
	input  wire logic                     i_reset,
	input  wire logic                     i_sclk,
	input  wire logic                     i_sdi,
	input  wire logic                     i_spi_en_n,
	input  wire logic [GAIN_W-1:0]        i_gain_word_port,
	input  wire logic signed [DATA_W-1:0] i_tx_word,
	input  wire logic                     i_filter_bypass,
	input  wire logic                     i_hd_pd_enable,
	input  wire logic                     i_tx_active,
	input  wire logic [PD_DLY_W-1:0]      i_pd_delay,
	output logic                          o_sdo,
	output logic                          o_sdo_oe,
	output logic                          o_word_take,
	output logic signed [DATA_W-1:0]      o_tx_word,
	output tx_gain_type                   o_gain,
	output logic [GAIN_W-1:0]             o_rx_gain,
	output logic [MIRROR_N_W-1:0]         o_mirror_gain,
	output logic [OFFSET_W-1:0]           o_mirror_offset,
	output logic                          o_tx_powered
);

	localparam int DLY_AW = $clog2(DLY_DEPTH);

	// Serial port state.
	logic                   sclk_prev_reg;
	logic [4:0]             bit_cnt_reg;
	logic [14:0]            shift_reg;
	logic [REG_W-1:0]       sdo_shift_reg;
	// Register file.
	logic [GAIN_W-1:0]      tx_code_reg;
	logic                   tx_spi_en_reg;
	logic [GAIN_W-1:0]      rx_gain_reg;
	logic [REG_W-1:0]       port_sel_reg;
	logic [REG_W-1:0]       format_reg;
	logic [REG_W-1:0]       routing_reg;
	logic                   mirror_ovr_reg;
	logic [MIRROR_N_W-1:0]  mirror_n_reg;
	logic [OFFSET_W-1:0]    offset_reg;
	// Data path and power state.
	logic [1:0]             div_cnt_reg;
	logic [DLY_AW-1:0]      wptr_reg;
	logic signed [DATA_W-1:0] dly_mem [DLY_DEPTH];
	pd_state_type           pd_state_reg;
	pd_state_type           pd_next;
	logic [PD_DLY_W-1:0]    pd_cnt_reg;

	// Returns true when a completed write targets the given offset.
	function automatic logic wr_hit(input logic wr, input spi_frame_type f,
			input logic [ADDR_W-1:0] a);
		return wr && (f.addr == a);
	endfunction

	// Serial frame decode; inputs share the clock, so no synchroniser is needed.
	spi_frame_type          frame;
	wire                    sclk_rise  = i_sclk & ~sclk_prev_reg;
	wire                    sclk_fall  = ~i_sclk & sclk_prev_reg;
	wire                    frame_done = sclk_rise && !i_spi_en_n && (bit_cnt_reg == SPI_LAST_BIT);
	wire                    head_done  = sclk_rise && !i_spi_en_n && (bit_cnt_reg == SPI_HEAD_END);
	wire                    head_rd    = shift_reg[ADDR_W-1];
	wire [ADDR_W-1:0]       head_addr  = {shift_reg[ADDR_W-2:0], i_sdi};
	wire                    wr_now     = frame_done && !frame.rd;
	assign frame = {shift_reg, i_sdi};

	// Write strobes per register.
	wire wr_tx_atten = wr_hit(wr_now, frame, ADDR_TX_ATTEN);
	wire wr_port_sel = wr_hit(wr_now, frame, ADDR_PORT_SEL);
	wire wr_format   = wr_hit(wr_now, frame, ADDR_FORMAT);
	wire wr_routing  = wr_hit(wr_now, frame, ADDR_ROUTING);
	wire wr_mirror   = wr_hit(wr_now, frame, ADDR_MIRROR);
	wire wr_offset   = wr_hit(wr_now, frame, ADDR_OFFSET);

	// Read-back selection; unmapped offsets read as zero.
	wire [REG_W-1:0] read_word =
		(head_addr == ADDR_TX_ATTEN) ? {1'b0, tx_spi_en_reg, tx_code_reg} :
		(head_addr == ADDR_PORT_SEL) ? port_sel_reg :
		(head_addr == ADDR_FORMAT)   ? format_reg :
		(head_addr == ADDR_ROUTING)  ? routing_reg :
		(head_addr == ADDR_MIRROR)   ? {mirror_ovr_reg, 4'h0, mirror_n_reg} :
		(head_addr == ADDR_OFFSET)   ? {5'h00, offset_reg} : 8'h00;

	// Shifts serial bits in on rising edges and read data out on falling edges.
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			sclk_prev_reg <= 1'b0;
			bit_cnt_reg   <= '0;
			shift_reg     <= '0;
			sdo_shift_reg <= '0;
			o_sdo         <= 1'b0;
			o_sdo_oe      <= 1'b0;
		end else begin
			sclk_prev_reg <= i_sclk;
			if (i_spi_en_n) begin
				bit_cnt_reg <= '0;
				o_sdo_oe    <= 1'b0;
			end else begin
				if (sclk_rise) begin
					shift_reg   <= {shift_reg[13:0], i_sdi};
					bit_cnt_reg <= bit_cnt_reg + 5'h01;
				end
				if (head_done && head_rd) begin
					sdo_shift_reg <= read_word;
					o_sdo_oe      <= 1'b1;
				end else if (sclk_fall && o_sdo_oe) begin
					o_sdo         <= sdo_shift_reg[REG_W-1];
					sdo_shift_reg <= {sdo_shift_reg[REG_W-2:0], 1'b0};
				end
			end
		end
	end

	// Gain registers: a serial write wins over the parallel port in the same cycle.
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			tx_code_reg   <= TX_CODE_RESET;
			tx_spi_en_reg <= 1'b0;
			rx_gain_reg   <= TX_CODE_RESET;
		end else begin
			if (wr_tx_atten) begin
				tx_spi_en_reg <= frame.data[SPI_UPDATE_BIT];
				if (frame.data[SPI_UPDATE_BIT]) begin
					tx_code_reg <= frame.data[GAIN_W-1:0];
				end
			end else if (port_sel_reg[SEL_TX_BIT]) begin
				tx_code_reg <= i_gain_word_port;
			end
			if (port_sel_reg[SEL_RX_BIT]) begin
				rx_gain_reg <= i_gain_word_port;
			end
		end
	end

	// Configuration registers.
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			port_sel_reg   <= PORT_SEL_RESET;
			format_reg     <= FORMAT_RESET;
			routing_reg    <= ROUTING_RESET;
			mirror_ovr_reg <= 1'b0;
			mirror_n_reg   <= MIRROR_N_RESET;
			offset_reg     <= OFFSET_RESET;
		end else begin
			if (wr_port_sel) port_sel_reg <= frame.data;
			if (wr_format) format_reg <= frame.data;
			if (wr_routing) routing_reg <= frame.data;
			if (wr_offset) offset_reg <= frame.data[OFFSET_W-1:0];
			if (wr_mirror && frame.data[MIRROR_OVR_BIT]) begin
				mirror_ovr_reg <= 1'b1;
				mirror_n_reg   <= (frame.data[MIRROR_N_W-1:0] > MIRROR_N_MAX) ?
					MIRROR_N_MAX : frame.data[MIRROR_N_W-1:0];
			end
		end
	end

	// Attenuation lookup: amplifier takes 6 dB steps, converter the 0.5 dB remainder.
	wire                direct      = routing_reg[DIRECT_OUT_BIT];
	wire [GAIN_W-1:0]   capped_code = (tx_code_reg > TOTAL_STEPS) ? TOTAL_STEPS : tx_code_reg;
	wire [1:0]          amp_step    = (capped_code >= AMP_UNIT2) ? 2'h2 :
		(capped_code >= AMP_UNIT) ? 2'h1 : 2'h0;
	wire [GAIN_W-1:0]   dac_full    = capped_code - ((amp_step == 2'h2) ? AMP_UNIT2 :
		(amp_step == 2'h1) ? AMP_UNIT : 6'h00);
	tx_gain_type        gain_next;
	// One driver for the whole struct keeps the fields from fighting over the variable.
	assign gain_next = '{
		dac_atten:  direct ? tx_code_reg[3:0] : dac_full[3:0],
		amp_step:   direct ? 2'h0 : amp_step,
		amp_enable: !direct
	};

	// Rate divider: one input word is taken per 1, 2 or 4 converter updates.
	wire       is2x     = format_reg[FMT_INTERP_LSB +: 2] == INTERP_2X;
	wire [1:0] div_last = i_filter_bypass ? DIV_LAST_BYP : is2x ? DIV_LAST_2X : DIV_LAST_4X;
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			div_cnt_reg <= '0;
			o_word_take <= 1'b0;
		end else begin
			div_cnt_reg <= (div_cnt_reg == div_last) ? 2'h0 : div_cnt_reg + 2'h1;
			o_word_take <= (div_cnt_reg == div_last);
		end
	end

	// Two cascaded half-band stages; 2x mode uses only the first.
	logic signed [DATA_W-1:0] s1_word;
	logic signed [DATA_W-1:0] s2_word;
	logic                     s1_valid;
	wire                      s1_out_en = is2x | ~div_cnt_reg[0];

	halfband_stage #(.HALF(HALF1), .COEF(COEF1)) first_stage (
		.i_mclk   (i_mclk),
		.i_reset  (i_reset),
		.i_in_en  (o_word_take),
		.i_out_en (s1_out_en),
		.i_word   (i_tx_word),
		.o_word   (s1_word),
		.o_valid  (s1_valid)
	);

	halfband_stage #(.HALF(HALF2), .COEF(COEF2)) second_stage (
		.i_mclk   (i_mclk),
		.i_reset  (i_reset),
		.i_in_en  (s1_valid),
		.i_out_en (1'b1),
		.i_word   (s1_word),
		.o_word   (s2_word),
		.o_valid  ()
	);

	// Alignment delay brings the filter latency to the fixed per-mode figure.
	wire signed [DATA_W-1:0] filt_word = is2x ? s1_word : s2_word;
	wire [DLY_AW-1:0]        rptr      = wptr_reg - DLY_AW'(is2x ? PAD_2X : PAD_4X);
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			wptr_reg  <= '0;
			o_tx_word <= '0;
			for (int k = 0; k < DLY_DEPTH; k++) begin
				dly_mem[k] <= '0;
			end
		end else begin
			wptr_reg          <= wptr_reg + DLY_AW'(1);
			dly_mem[wptr_reg] <= filt_word;
			o_tx_word         <= i_filter_bypass ? i_tx_word : dly_mem[rptr];
		end
	end

	// Half-duplex power-down waits the programmed number of input words.
	always_comb begin
		unique case (pd_state_reg)
			PD_ON: pd_next = (i_hd_pd_enable && !i_tx_active) ? PD_WAIT : PD_ON;
			PD_WAIT: pd_next = (!i_hd_pd_enable || i_tx_active) ? PD_ON :
				(pd_cnt_reg >= i_pd_delay) ? PD_OFF : PD_WAIT;
			PD_OFF: pd_next = (!i_hd_pd_enable || i_tx_active) ? PD_ON : PD_OFF;
			default: pd_next = PD_ON; // The unused code recovers to powered.
		endcase
	end

	// Power state, delay counter and registered outputs.
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			pd_state_reg <= PD_ON;
			pd_cnt_reg   <= '0;
			o_tx_powered <= 1'b1;
			o_gain       <= '{dac_atten: 4'h0, amp_step: 2'h0, amp_enable: 1'b1};
		end else begin
			pd_state_reg <= pd_next;
			pd_cnt_reg   <= (pd_state_reg != PD_WAIT) ? '0 :
				pd_cnt_reg + PD_DLY_W'(o_word_take);
			o_tx_powered <= (pd_next != PD_OFF);
			o_gain       <= gain_next;
		end
	end

	assign o_rx_gain       = rx_gain_reg;
	assign o_mirror_gain   = mirror_n_reg;
	assign o_mirror_offset = offset_reg;

	// Checks on the behaviour above.
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_reset);

	wire fourx = !i_filter_bypass && !is2x;
	// A take pulse followed by three more cycles that stay in 4x mode.
	sequence four_run;
		o_word_take && fourx && $past(fourx) ##1 fourx [*3];
	endsequence
	sequence quiet_wait;
		(pd_state_reg == PD_WAIT) && i_hd_pd_enable && !i_tx_active;
	endsequence

	port_tx_load_a: assert property (
		port_sel_reg[SEL_TX_BIT] && !wr_tx_atten |=> tx_code_reg == $past(i_gain_word_port))
		else $error("Parallel port did not load the attenuation code.");
	port_idle_a: assert property (
		!port_sel_reg[SEL_TX_BIT] && !port_sel_reg[SEL_RX_BIT] && !wr_tx_atten
		|=> $stable(tx_code_reg) && $stable(rx_gain_reg))
		else $error("Gain changed with no port selected.");
	mirror_guard_a: assert property (
		wr_mirror && !frame.data[MIRROR_OVR_BIT] |=> $stable(mirror_n_reg))
		else $error("Mirror gain changed without override.");
	spi_code_write_a: assert property (
		wr_tx_atten && frame.data[SPI_UPDATE_BIT] |=> tx_code_reg == $past(frame.data[5:0]))
		else $error("Serial write did not set the attenuation code.");
	direct_map_a: assert property (
		direct && $stable(tx_code_reg) |=> o_gain.dac_atten == $past(tx_code_reg[3:0])
		&& o_gain.amp_step == 2'h0)
		else $error("Direct output mapping wrong.");
	composite_map_a: assert property (
		!direct |=> 6'(o_gain.amp_step * AMP_UNIT) + 6'(o_gain.dac_atten) == $past(capped_code))
		else $error("Composite attenuation split wrong.");
	amp_route_a: assert property (
		o_gain.amp_enable == !$past(direct))
		else $error("Amplifier enable does not follow routing.");
	take_rate_a: assert property (
		four_run |=> o_word_take && !$past(o_word_take) && !$past(o_word_take, 2)
		&& !$past(o_word_take, 3))
		else $error("4x mode does not take one word per four updates.");
	bypass_pass_a: assert property (
		i_filter_bypass |=> o_tx_word == $past(i_tx_word))
		else $error("Bypass did not pass the input word.");
	pd_delay_a: assert property (
		quiet_wait ##0 (pd_cnt_reg < i_pd_delay) |=> o_tx_powered)
		else $error("Powered down before the delay elapsed.");

endmodule

// [tx_gain_pkg.sv]
// Shared constants, types and register map for the transmit interpolation and gain block.
package tx_gain_pkg;

	// Data path and register widths.
	localparam int DATA_W = 10;
	localparam int GAIN_W = 6;
	localparam int ADDR_W = 7;
	localparam int REG_W  = 8;

	// Register offsets on the serial port.
	localparam logic [ADDR_W-1:0] ADDR_TX_ATTEN  = 7'h0A;
	localparam logic [ADDR_W-1:0] ADDR_PORT_SEL  = 7'h0B;
	localparam logic [ADDR_W-1:0] ADDR_FORMAT    = 7'h0C;
	localparam logic [ADDR_W-1:0] ADDR_ROUTING   = 7'h0E;
	localparam logic [ADDR_W-1:0] ADDR_MIRROR    = 7'h10;
	localparam logic [ADDR_W-1:0] ADDR_OFFSET    = 7'h12;

	// Field positions.
	localparam int SPI_UPDATE_BIT = 6;
	localparam int SEL_TX_BIT     = 6;
	localparam int SEL_RX_BIT     = 5;
	localparam int FMT_INTERP_LSB = 6;
	localparam int DIRECT_OUT_BIT = 0;
	localparam int MIRROR_OVR_BIT = 7;
	localparam int MIRROR_N_W     = 3;
	localparam int OFFSET_W       = 3;

	// Reset values.
	localparam logic [GAIN_W-1:0]     TX_CODE_RESET  = 6'h00;
	localparam logic [REG_W-1:0]      PORT_SEL_RESET = 8'h00;
	localparam logic [REG_W-1:0]      FORMAT_RESET   = 8'h00;
	localparam logic [REG_W-1:0]      ROUTING_RESET  = 8'h00;
	localparam logic [MIRROR_N_W-1:0] MIRROR_N_RESET = 3'h4;
	localparam logic [MIRROR_N_W-1:0] MIRROR_N_MAX   = 3'h4;
	localparam logic [OFFSET_W-1:0]   OFFSET_RESET   = 3'h0;

	// Interpolation factor codes.
	localparam logic [1:0] INTERP_4X = 2'h0;
	localparam logic [1:0] INTERP_2X = 2'h1;

	// Attenuation spans in milli-dB and the step counts derived from them.
	localparam int STEP_MDB     = 500;
	localparam int DAC_SPAN_MDB = 7500;
	localparam int AMP_SPAN_MDB = 19500;
	localparam int AMP_STEP_MDB = 6000;
	localparam logic [GAIN_W-1:0] DAC_STEPS   = 6'(DAC_SPAN_MDB / STEP_MDB);
	localparam logic [GAIN_W-1:0] TOTAL_STEPS = 6'(AMP_SPAN_MDB / STEP_MDB);
	localparam logic [GAIN_W-1:0] AMP_UNIT    = 6'(AMP_STEP_MDB / STEP_MDB);
	localparam logic [GAIN_W-1:0] AMP_UNIT2   = 6'(2 * AMP_STEP_MDB / STEP_MDB);

	// Serial frame: read flag, seven address bits, eight data bits.
	localparam logic [4:0] SPI_LAST_BIT = 5'(16 - 1);
	localparam logic [4:0] SPI_HEAD_END = 5'(8 - 1);

	// Rates: the clock is the converter update clock.
	localparam int CLK_HZ       = 20_000_000;
	localparam int MAX_IN_MSPS  = 80;
	localparam int MAX_DAC_MSPS = 200;
	localparam int CLK_PER_IN_2X = 2;
	localparam int CLK_PER_IN_4X = 4;
	localparam logic [1:0] DIV_LAST_BYP = 2'h0;
	localparam logic [1:0] DIV_LAST_2X  = 2'(CLK_PER_IN_2X - 1);
	localparam logic [1:0] DIV_LAST_4X  = 2'(CLK_PER_IN_4X - 1);

	// Half-band stages: tap counts and nonzero coefficient pairs.
	localparam int TAPS1     = 43;
	localparam int TAPS2     = 11;
	localparam int HALF1     = (TAPS1 + 1) / 4;
	localparam int HALF2     = (TAPS2 + 1) / 4;
	localparam int COEF_FRAC = 15;
	typedef logic signed [15:0] coef_type;
	localparam coef_type COEF1 [HALF1] = '{16'sh50B4, 16'shE520, 16'sh100E, 16'shF4C0,
		16'sh0866, 16'shF998, 16'sh04D8, 16'shFC68, 16'sh0294, 16'shFE48, 16'sh0144};
	localparam coef_type COEF2 [HALF2] = '{16'sh4E20, 16'shEE00, 16'sh03E0};

	// Latency in half input periods, then in clocks, and the alignment padding.
	localparam int LAT2X_HALF  = 43;
	localparam int LAT4X_HALF  = 48;
	localparam int LAT2X_CLK   = LAT2X_HALF * CLK_PER_IN_2X / 2;
	localparam int LAT4X_CLK   = LAT4X_HALF * CLK_PER_IN_4X / 2;
	localparam int FILT2X_CLK  = HALF1 * CLK_PER_IN_2X + 2;
	localparam int FILT4X_CLK  = HALF1 * CLK_PER_IN_4X + HALF2 * 2 + 4;
	localparam logic [5:0] PAD_2X = 6'(LAT2X_CLK - FILT2X_CLK);
	localparam logic [5:0] PAD_4X = 6'(LAT4X_CLK - FILT4X_CLK);

	typedef enum logic [1:0] {PD_ON, PD_WAIT, PD_OFF} pd_state_type;

	typedef struct packed {
		logic [3:0] dac_atten;
		logic [1:0] amp_step;
		logic       amp_enable;
	} tx_gain_type;

	typedef struct packed {
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [REG_W-1:0]  data;
	} spi_frame_type;

endpackage

// [halfband_stage.sv]
// One half-band 2x interpolation stage with saturating output.
module halfband_stage
	import tx_gain_pkg::*;
#(
	parameter int       HALF = HALF2,
	parameter coef_type COEF [HALF] = COEF2
) (
	input  wire logic                     i_mclk,
	input  wire logic                     i_reset,
	input  wire logic                     i_in_en,
	input  wire logic                     i_out_en,
	input  wire logic signed [DATA_W-1:0] i_word,
	output logic signed [DATA_W-1:0]      o_word,
	output logic                          o_valid
);

	localparam int ACC_W = 32;
	localparam logic signed [ACC_W-1:0] SAT_HI = ACC_W'(2 ** (DATA_W - 1) - 1);
	localparam logic signed [ACC_W-1:0] SAT_LO = ACC_W'(-(2 ** (DATA_W - 1)));

	logic signed [DATA_W-1:0] hist_reg [2*HALF];
	logic                     phase_reg;
	logic signed [ACC_W-1:0]  acc;
	logic signed [ACC_W-1:0]  scaled;
	logic signed [DATA_W-1:0] odd_word;
	logic signed [DATA_W-1:0] even_word;

	// Multiplies one coefficient by the sum of its symmetric sample pair.
	function automatic logic signed [ACC_W-1:0] pair_term(input coef_type c,
			input logic signed [DATA_W-1:0] a, input logic signed [DATA_W-1:0] b);
		logic signed [DATA_W:0] s;
		s = (DATA_W+1)'(a) + (DATA_W+1)'(b);
		return ACC_W'(c) * ACC_W'(s);
	endfunction

	// Only odd taps are nonzero, so the new phase is a sum of symmetric pairs.
	always_comb begin
		acc = '0;
		for (int k = 0; k < HALF; k++) begin
			acc = acc + pair_term(COEF[k], hist_reg[HALF-1-k], hist_reg[HALF+k]);
		end
	end

	// Scale back from the coefficient fraction and clip to the word range.
	assign scaled    = acc >>> COEF_FRAC;
	assign odd_word  = (scaled > SAT_HI) ? SAT_HI[DATA_W-1:0] :
		(scaled < SAT_LO) ? SAT_LO[DATA_W-1:0] : scaled[DATA_W-1:0];
	assign even_word = hist_reg[HALF-1];

	// Sample history shifts once per input word.
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			for (int k = 0; k < 2 * HALF; k++) begin
				hist_reg[k] <= '0;
			end
		end else if (i_in_en) begin
			hist_reg[0] <= i_word;
			for (int k = 1; k < 2 * HALF; k++) begin
				hist_reg[k] <= hist_reg[k-1];
			end
		end
	end

	// Each output slot alternates between the filtered and the centre phase.
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			o_word    <= '0;
			o_valid   <= 1'b0;
			phase_reg <= 1'b0;
		end else begin
			o_valid <= i_out_en;
			if (i_out_en) begin
				o_word    <= (i_in_en || phase_reg) ? odd_word : even_word;
				phase_reg <= !i_in_en;
			end
		end
	end

endmodule

// [tx_word_source.sv]
// Back-end model that hands a fresh transmit word after each take.
module tx_word_source
	import tx_gain_pkg::*;
(
	input  wire logic                i_mclk,
	input  wire logic                i_reset,
	input  wire logic                i_take,
	output logic signed [DATA_W-1:0] o_word
);
	timeunit 1ns;
	timeprecision 1ns;
	// Step the word only when the block has taken the current one.
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			o_word <= 10'sh001;
		end else if (i_take) begin
			o_word <= o_word + 10'sh003;
		end
	end
endmodule

// [tx_interpolation_gain_control_tb.sv]
// Self-checking bench for the transmit interpolation and gain block.
module tx_interpolation_gain_control_tb
	import tx_gain_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;
	logic                     mclk, reset, sclk, sdi, spi_en_n;
	logic                     bypass, hd_en, tx_active;
	logic                     sdo, sdo_oe, take, powered;
	logic [GAIN_W-1:0]        gport, rx_gain;
	logic [7:0]               pd_dly, rd;
	logic signed [DATA_W-1:0] tx_word, out_word;
	logic [MIRROR_N_W-1:0]    mir_n;
	logic [OFFSET_W-1:0]      mir_off;
	tx_gain_type              gain;
	int                       err_count = 0;
	int                       cmp_count = 0;
	int                       codes[8] = '{0, 11, 12, 23, 24, 39, 45, 63};

	tx_interpolation_gain_control tx_interpolation_gain_control_inst (
		.i_mclk(mclk), .i_reset(reset), .i_sclk(sclk), .i_sdi(sdi),
		.i_spi_en_n(spi_en_n), .i_gain_word_port(gport), .i_tx_word(tx_word),
		.i_filter_bypass(bypass), .i_hd_pd_enable(hd_en), .i_tx_active(tx_active),
		.i_pd_delay(pd_dly), .o_sdo(sdo), .o_sdo_oe(sdo_oe), .o_word_take(take),
		.o_tx_word(out_word), .o_gain(gain), .o_rx_gain(rx_gain),
		.o_mirror_gain(mir_n), .o_mirror_offset(mir_off), .o_tx_powered(powered));
	tx_word_source tx_word_source_inst (
		.i_mclk(mclk), .i_reset(reset), .i_take(take), .o_word(tx_word));

	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic gchk(input logic [3:0] d, input logic [1:0] s, input logic en);
		chk(16'(gain), 16'({d, s, en}));
	endtask

	// One serial frame, read bits sampled late in each low phase of the clock.
	task automatic spi(input logic [15:0] f);
		@(posedge mclk) spi_en_n <= 1'b0;
		for (int i = 15; i >= 0; i--) begin
			@(posedge mclk) sdi <= f[i];
			repeat (3) @(posedge mclk);
			if (i < 8) rd[i] = sdo;
			if (i < 8 && f[15]) chk(16'(sdo_oe), 16'h0001);
			@(posedge mclk) sclk <= 1'b1;
			repeat (3) @(posedge mclk);
			@(posedge mclk) sclk <= 1'b0;
		end
		@(posedge mclk) spi_en_n <= 1'b1;
		repeat (3) @(posedge mclk);
		#1;
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		spi({1'b0, a, d});
	endtask

	task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
		spi({1'b1, a, 8'h00});
		chk(16'(rd), 16'(e));
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic t_reset;
		gchk(4'h0, 2'h0, 1'b1);
		chk(16'(mir_n), 16'(MIRROR_N_RESET));
		rdchk(ADDR_TX_ATTEN, 8'h00);
		rdchk(7'h20, 8'h00);
	endtask

	task automatic t_serial;
		int k, s;
		wr(ADDR_TX_ATTEN, 8'h45);
		gchk(4'h5, 2'h0, 1'b1);
		rdchk(ADDR_TX_ATTEN, 8'h45);
		wr(ADDR_TX_ATTEN, 8'h03);
		gchk(4'h5, 2'h0, 1'b1);
		rdchk(ADDR_TX_ATTEN, 8'h05);
		foreach (codes[i]) begin
			k = (codes[i] > 39) ? 39 : codes[i];
			s = (k >= 24) ? 2 : (k >= 12) ? 1 : 0;
			wr(ADDR_TX_ATTEN, 8'h40 | 8'(codes[i]));
			gchk(4'(k - 12 * s), 2'(s), 1'b1);
		end
		wr(ADDR_ROUTING, 8'h01);
		rdchk(ADDR_ROUTING, 8'h01);
		wr(ADDR_TX_ATTEN, 8'h55);
		chk(16'(gain.dac_atten), 16'h0005);
		chk(16'(gain.amp_enable), 16'h0000);
		wr(ADDR_ROUTING, 8'h00);
		chk(16'(gain.amp_enable), 16'h0001);
	endtask

	task automatic t_port;
		@(posedge mclk) gport <= 6'h21;
		wr(ADDR_PORT_SEL, 8'h40);
		gchk(4'h9, 2'h2, 1'b1);
		@(posedge mclk) gport <= 6'h0E;
		wait_cyc(2);
		gchk(4'h2, 2'h1, 1'b1);
		wr(ADDR_PORT_SEL, 8'h20);
		@(posedge mclk) gport <= 6'h11;
		wait_cyc(3);
		chk(16'(rx_gain), 16'h0011);
		gchk(4'h2, 2'h1, 1'b1);
		wr(ADDR_PORT_SEL, 8'h00);
		@(posedge mclk) gport <= 6'h3F;
		wait_cyc(3);
		chk(16'(rx_gain), 16'h0011);
		gchk(4'h2, 2'h1, 1'b1);
		rdchk(ADDR_PORT_SEL, 8'h00);
	endtask

	task automatic t_mirror;
		wr(ADDR_MIRROR, 8'h02);
		chk(16'(mir_n), 16'h0004);
		wr(ADDR_MIRROR, 8'h82);
		chk(16'(mir_n), 16'h0002);
		rdchk(ADDR_MIRROR, 8'h82);
		wr(ADDR_MIRROR, 8'h87);
		chk(16'(mir_n), 16'h0004);
		wr(ADDR_OFFSET, 8'h05);
		rdchk(ADDR_OFFSET, 8'h05);
		wr(ADDR_OFFSET, 8'h00);
		chk(16'(mir_off), 16'h0000);
		wr(ADDR_MIRROR, 8'h84);
		chk(16'(mir_n), 16'(MIRROR_N_RESET));
	endtask

	// Count clocks between two take pulses.
	task automatic period(input int exp);
		int n;
		for (n = 0; n < 20 && take !== 1'b1; n++) @(posedge mclk) #1;
		@(posedge mclk) #1;
		for (n = 1; n < 20 && take !== 1'b1; n++) @(posedge mclk) #1;
		chk(16'(n), 16'(exp));
	endtask

	task automatic t_path;
		logic signed [DATA_W-1:0] w;
		@(posedge mclk) bypass <= 1'b1;
		wait_cyc(5);
		repeat (4) begin
			w = tx_word;
			wait_cyc(1);
			chk(16'(out_word), 16'(w));
			chk(16'(take), 16'h0001);
		end
		@(posedge mclk) bypass <= 1'b0;
		wr(ADDR_FORMAT, 8'h40);
		rdchk(ADDR_FORMAT, 8'h40);
		period(2);
		wr(ADDR_FORMAT, 8'h00);
		period(4);
		// The filtered ramp must keep moving once the pipeline has filled.
		wait_cyc(120);
		w = out_word;
		wait_cyc(16);
		chk(16'(out_word != w), 16'h0001);
	endtask

	task automatic t_power;
		int n;
		@(posedge mclk) bypass <= 1'b1;
		pd_dly <= 8'h03;
		hd_en <= 1'b1;
		tx_active <= 1'b0;
		wait_cyc(2);
		chk(16'(powered), 16'h0001);
		for (n = 2; n < 50 && powered !== 1'b0; n++) wait_cyc(1);
		chk(16'(n >= 4 && n <= 8), 16'h0001);
		@(posedge mclk) tx_active <= 1'b1;
		wait_cyc(2);
		chk(16'(powered), 16'h0001);
	endtask

	// Clock and hang watchdog.
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	initial begin
		#2ms;
		err_count++;
		print_verdict();
	end

	// Reset, then the scenarios in turn.
	initial begin
		{reset, spi_en_n, tx_active} = 3'h7;
		{sclk, sdi, bypass, hd_en} = 4'h0;
		gport = 6'h00;
		pd_dly = 8'h00;
		repeat (16) @(posedge mclk);
		reset <= 1'b0;
		wait_cyc(1);
		t_reset();
		t_serial();
		t_port();
		t_mirror();
		t_path();
		t_power();
		print_verdict();
	end
endmodule
